// >>> rtl/ppcb_pkg.sv
// Package holding the register map, reset values and carrier types of the port configuration bank.
package ppcb_pkg;

    // Register addresses on the special function register bus.
    localparam logic [7:0] PORT1_DATA_LATCH_ADDR = 8'h90;
    localparam logic [7:0] PORT0_OUTPUT_MODE_ADDR = 8'ha4;
    localparam logic [7:0] PORT0_DRIVE_STRENGTH_ADDR = 8'ha4;
    localparam logic [7:0] PORT0_CROSSBAR_SKIP_ADDR = 8'hd4;
    localparam logic [7:0] PORT1_CROSSBAR_SKIP_ADDR = 8'hd5;
    localparam logic [7:0] PORT0_INPUT_MODE_ADDR = 8'hf1;

    // Register pages; the data latch answers on every page.
    localparam logic [3:0] PAGE_CONFIG = 4'h0;
    localparam logic [3:0] PAGE_DRIVE = 4'hf;

    // Reset values.
    localparam logic [7:0] PORT1_DATA_LATCH_RST = 8'hff;
    localparam logic [7:0] PORT0_OUTPUT_MODE_RST = 8'h00;
    localparam logic [7:0] PORT0_DRIVE_STRENGTH_RST = 8'h00;
    localparam logic [7:0] PORT0_CROSSBAR_SKIP_RST = 8'h00;
    localparam logic [7:0] PORT1_CROSSBAR_SKIP_RST = 8'h00;
    localparam logic [7:0] PORT0_INPUT_MODE_RST = 8'hff;

    // Answer when no register is selected.
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    // Register select decoded from address and page.
    typedef enum logic [2:0] {
        PPCB_SEL_NONE = 3'b000,
        PPCB_SEL_P1_DATA = 3'b001,
        PPCB_SEL_P0_OMODE = 3'b010,
        PPCB_SEL_P0_DRIVE = 3'b011,
        PPCB_SEL_P0_SKIP = 3'b100,
        PPCB_SEL_P1_SKIP = 3'b101,
        PPCB_SEL_P0_IMODE = 3'b110
    } ppcb_sel_type;

    // One bus request from the CPU.
    typedef struct packed {
        logic wr;
        logic rd;
        logic rmw;
        logic bit_op;
        logic [2:0] bit_idx;
        logic bit_val;
        logic [7:0] addr;
        logic [3:0] page;
        logic [7:0] wdata;
    } ppcb_req_type;

    // Port 0 configuration vectors presented to the pads.
    typedef struct packed {
        logic [7:0] skip;
        logic [7:0] digital_mode;
        logic [7:0] push_pull;
        logic [7:0] high_drive;
    } ppcb_p0_cfg_type;

endpackage

// >>> rtl/ppcb_decode.sv
// Address and page decoder that picks one register of the bank.
`timescale 1ns/1ps
module ppcb_decode (
    input wire logic [7:0] addr,
    input wire logic [3:0] page,
    output ppcb_pkg::ppcb_sel_type sel
);

    // Page-qualified decode; the data latch ignores the page.
    always_comb begin
        if (addr == ppcb_pkg::PORT1_DATA_LATCH_ADDR) begin
            sel = ppcb_pkg::PPCB_SEL_P1_DATA;
        end else if (addr == ppcb_pkg::PORT0_OUTPUT_MODE_ADDR && page == ppcb_pkg::PAGE_CONFIG) begin
            sel = ppcb_pkg::PPCB_SEL_P0_OMODE;
        end else if (addr == ppcb_pkg::PORT0_DRIVE_STRENGTH_ADDR && page == ppcb_pkg::PAGE_DRIVE) begin
            sel = ppcb_pkg::PPCB_SEL_P0_DRIVE;
        end else if (addr == ppcb_pkg::PORT0_CROSSBAR_SKIP_ADDR && page == ppcb_pkg::PAGE_CONFIG) begin
            sel = ppcb_pkg::PPCB_SEL_P0_SKIP;
        end else if (addr == ppcb_pkg::PORT1_CROSSBAR_SKIP_ADDR && page == ppcb_pkg::PAGE_CONFIG) begin
            sel = ppcb_pkg::PPCB_SEL_P1_SKIP;
        end else if (addr == ppcb_pkg::PORT0_INPUT_MODE_ADDR && page == ppcb_pkg::PAGE_CONFIG) begin
            sel = ppcb_pkg::PPCB_SEL_P0_IMODE;
        end else begin
            sel = ppcb_pkg::PPCB_SEL_NONE;
        end
    end

endmodule

// >>> rtl/ppcb_port_bank.sv
// Port 0 and Port 1 configuration and data register bank on the special function register bus.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////////////////////////////
module ppcb_port_bank (
    input wire logic sys_clk,
    input wire logic arst_n,
    input ppcb_pkg::ppcb_req_type req,
    input wire logic [7:0] port1_pin_level,
    output logic [7:0] rdata,
    output ppcb_pkg::ppcb_p0_cfg_type port0_cfg,
    output logic [7:0] port1_crossbar_skip,
    output logic [7:0] port1_data_latch,
    output logic [7:0] port0_pullup_en,
    output logic [7:0] port0_receiver_en
);

    ppcb_pkg::ppcb_sel_type sel;
    logic [7:0] skip0_q;
    logic [7:0] skip1_q;
    logic [7:0] imode_q;
    logic [7:0] omode_q;
    logic [7:0] drive_q;
    logic [7:0] latch_q;
    logic [7:0] latch_d;
    logic [7:0] rdata_d;

    // Merge a single-bit write into a byte, or pass the whole byte.
    function automatic logic [7:0] merge_write(input logic [7:0] old, input ppcb_pkg::ppcb_req_type r);
        logic [7:0] v;
        v = old;
        if (r.bit_op) begin
            v[r.bit_idx] = r.bit_val;
        end else begin
            v = r.wdata;
        end
        return v;
    endfunction

    ppcb_decode u_decode (
        .addr(req.addr),
        .page(req.page),
        .sel(sel)
    );

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // Configuration registers; each updates on its own decoded write.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            skip0_q <= ppcb_pkg::PORT0_CROSSBAR_SKIP_RST;
            skip1_q <= ppcb_pkg::PORT1_CROSSBAR_SKIP_RST;
            imode_q <= ppcb_pkg::PORT0_INPUT_MODE_RST;
            omode_q <= ppcb_pkg::PORT0_OUTPUT_MODE_RST;
            drive_q <= ppcb_pkg::PORT0_DRIVE_STRENGTH_RST;
        end else if (req.wr) begin
            if (sel == ppcb_pkg::PPCB_SEL_P0_SKIP) begin
                skip0_q <= merge_write(skip0_q, req);
            end
            if (sel == ppcb_pkg::PPCB_SEL_P1_SKIP) begin
                skip1_q <= merge_write(skip1_q, req);
            end
            if (sel == ppcb_pkg::PPCB_SEL_P0_IMODE) begin
                imode_q <= merge_write(imode_q, req);
            end
            if (sel == ppcb_pkg::PPCB_SEL_P0_OMODE) begin
                omode_q <= merge_write(omode_q, req);
            end
            if (sel == ppcb_pkg::PPCB_SEL_P0_DRIVE) begin
                drive_q <= merge_write(drive_q, req);
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // Port 1 output latch; bit writes touch only their bit so other pins keep their drive.
    always_comb begin
        latch_d = latch_q;
        if (req.wr && sel == ppcb_pkg::PPCB_SEL_P1_DATA) begin
            latch_d = merge_write(latch_q, req);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            latch_q <= ppcb_pkg::PORT1_DATA_LATCH_RST;
        end else begin
            latch_q <= latch_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // Read mux; read-modify-write sees the latch so a pin held low externally is not copied back.
    always_comb begin
        rdata_d = ppcb_pkg::UNMAPPED_READ_VALUE;
        if (sel == ppcb_pkg::PPCB_SEL_P1_DATA) begin
            rdata_d = req.rmw ? latch_q : port1_pin_level;
        end else if (sel == ppcb_pkg::PPCB_SEL_P0_SKIP) begin
            rdata_d = skip0_q;
        end else if (sel == ppcb_pkg::PPCB_SEL_P1_SKIP) begin
            rdata_d = skip1_q;
        end else if (sel == ppcb_pkg::PPCB_SEL_P0_IMODE) begin
            rdata_d = imode_q;
        end else if (sel == ppcb_pkg::PPCB_SEL_P0_OMODE) begin
            rdata_d = omode_q;
        end else if (sel == ppcb_pkg::PPCB_SEL_P0_DRIVE) begin
            rdata_d = drive_q;
        end
    end

    // Read data is registered, valid the cycle after the read strobe; held otherwise.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= ppcb_pkg::UNMAPPED_READ_VALUE;
        end else if (req.rd) begin
            rdata <= rdata_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // Output vectors are flopped copies, so they move one cycle after the register takes a write.
    // Analog mode gates pull-up and receiver, but push-pull and drive pass untouched.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            port0_cfg <= '{skip: ppcb_pkg::PORT0_CROSSBAR_SKIP_RST,
                           digital_mode: ppcb_pkg::PORT0_INPUT_MODE_RST,
                           push_pull: ppcb_pkg::PORT0_OUTPUT_MODE_RST,
                           high_drive: ppcb_pkg::PORT0_DRIVE_STRENGTH_RST};
            port1_crossbar_skip <= ppcb_pkg::PORT1_CROSSBAR_SKIP_RST;
            port1_data_latch <= ppcb_pkg::PORT1_DATA_LATCH_RST;
            port0_pullup_en <= ppcb_pkg::PORT0_INPUT_MODE_RST;
            port0_receiver_en <= ppcb_pkg::PORT0_INPUT_MODE_RST;
        end else begin
            port0_cfg <= '{skip: skip0_q, digital_mode: imode_q, push_pull: omode_q,
                           high_drive: drive_q};
            port1_crossbar_skip <= skip1_q;
            port1_data_latch <= latch_q;
            port0_pullup_en <= imode_q;
            port0_receiver_en <= imode_q;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence s_latch_write;
        req.wr && sel == ppcb_pkg::PPCB_SEL_P1_DATA && !req.bit_op;
    endsequence

    chk_latch_write_out: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_latch_write |-> ##2 port1_data_latch == $past(req.wdata, 2))
        else $error("Port 1 latch output did not follow byte write.");

    chk_plain_read_pins: assert property (@(posedge sys_clk) disable iff (!arst_n)
        req.rd && !req.rmw && sel == ppcb_pkg::PPCB_SEL_P1_DATA |=> rdata == $past(port1_pin_level))
        else $error("Plain read did not return pin levels.");

    chk_rmw_read_latch: assert property (@(posedge sys_clk) disable iff (!arst_n)
        req.rd && req.rmw && sel == ppcb_pkg::PPCB_SEL_P1_DATA |=> rdata == $past(latch_q))
        else $error("Read-modify-write did not read the latch.");

    chk_data_any_page: assert property (@(posedge sys_clk) disable iff (!arst_n)
        req.addr == ppcb_pkg::PORT1_DATA_LATCH_ADDR |-> sel == ppcb_pkg::PPCB_SEL_P1_DATA)
        else $error("Data register not selected on every page.");

    chk_page_split_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
        req.wr && req.addr == ppcb_pkg::PORT0_OUTPUT_MODE_ADDR && req.page == ppcb_pkg::PAGE_DRIVE
        |=> $stable(omode_q))
        else $error("Drive page write disturbed output mode.");

    chk_bit_write_only: assert property (@(posedge sys_clk) disable iff (!arst_n)
        req.wr && req.bit_op && sel == ppcb_pkg::PPCB_SEL_P1_DATA
        |=> latch_q[$past(req.bit_idx)] == $past(req.bit_val))
        else $error("Bit write did not land on its bit.");

    chk_skip_follows: assert property (@(posedge sys_clk) disable iff (!arst_n)
        req.wr && !req.bit_op && sel == ppcb_pkg::PPCB_SEL_P0_SKIP |-> ##2 port0_cfg.skip == $past(req.wdata, 2))
        else $error("Port 0 skip vector did not follow write.");

    chk_analog_gating: assert property (@(posedge sys_clk) disable iff (!arst_n)
        ##1 (port0_pullup_en == $past(imode_q)) && (port0_receiver_en == port0_cfg.digital_mode))
        else $error("Analog gating does not match input mode.");

    chk_pushpull_kept: assert property (@(posedge sys_clk) disable iff (!arst_n)
        ##1 port0_cfg.push_pull == $past(omode_q))
        else $error("Output mode vector lost in analog mode.");

    chk_drive_follows: assert property (@(posedge sys_clk) disable iff (!arst_n)
        req.wr && !req.bit_op && sel == ppcb_pkg::PPCB_SEL_P0_DRIVE
        |-> ##2 port0_cfg.high_drive == $past(req.wdata, 2))
        else $error("Drive vector did not follow write.");

    chk_bit_write_others: assert property (@(posedge sys_clk) disable iff (!arst_n)
        req.wr && req.bit_op && sel == ppcb_pkg::PPCB_SEL_P1_DATA
        |=> ((latch_q ^ $past(latch_q)) & ~(8'h01 << $past(req.bit_idx))) == 8'h00)
        else $error("Bit write disturbed another latch bit.");

    chk_imode_follows: assert property (@(posedge sys_clk) disable iff (!arst_n)
        req.wr && !req.bit_op && sel == ppcb_pkg::PPCB_SEL_P0_IMODE
        |-> ##2 port0_cfg.digital_mode == $past(req.wdata, 2))
        else $error("Input mode vector did not follow write.");

    chk_omode_follows: assert property (@(posedge sys_clk) disable iff (!arst_n)
        req.wr && !req.bit_op && sel == ppcb_pkg::PPCB_SEL_P0_OMODE
        |-> ##2 port0_cfg.push_pull == $past(req.wdata, 2))
        else $error("Output mode vector did not follow write.");

    chk_p1_skip_follows: assert property (@(posedge sys_clk) disable iff (!arst_n)
        req.wr && !req.bit_op && sel == ppcb_pkg::PPCB_SEL_P1_SKIP
        |-> ##2 port1_crossbar_skip == $past(req.wdata, 2))
        else $error("Port 1 skip vector did not follow write.");

    // An unselected read must not leak a stale register value onto the bus.
    chk_unmapped_read: assert property (@(posedge sys_clk) disable iff (!arst_n)
        req.rd && sel == ppcb_pkg::PPCB_SEL_NONE |=> rdata == ppcb_pkg::UNMAPPED_READ_VALUE)
        else $error("Unmapped read did not return the idle value.");

    chk_refused_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
        req.wr && sel == ppcb_pkg::PPCB_SEL_NONE
        |=> $stable(skip0_q) && $stable(skip1_q) && $stable(imode_q) && $stable(omode_q) && $stable(drive_q))
        else $error("Write on a wrong page changed a register.");

endmodule

// >>> test/ppcb_pad_model.sv
// Pad model that turns the Port 1 output latch and outside pull-downs into pin levels.
`timescale 1ns/1ps
module ppcb_pad_model (
    input wire logic [7:0] latch,
    input wire logic [7:0] ext_low,
    output logic [7:0] pin_level
);
    // An outside pull-down wins over a high latch, so pins and latch can differ on command.
    assign pin_level = latch & ~ext_low;
endmodule

// >>> test/port_pin_config_bank_bench.sv
// Self-checking bench for the port configuration and data register bank.
`timescale 1ns/1ps
module port_pin_config_bank_bench;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    ppcb_pkg::ppcb_req_type req = '0;
    logic [7:0] ext_low = 8'h00;
    logic [7:0] pin_level, rdata, p1_skip, p1_latch, pullup_en, receiver_en;
    ppcb_pkg::ppcb_p0_cfg_type p0_cfg;
    logic [7:0] m [7];
    logic [7:0] exp_q [$];
    logic [7:0] ta [6] = '{8'h90, 8'ha4, 8'ha4, 8'hd4, 8'hd5, 8'hf1};
    logic [3:0] tp [6] = '{4'h0, 4'h0, 4'hf, 4'h0, 4'h0, 4'h0};
    logic rd_d = 1'b0;
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [7:0] x;
    ////////////////////////////////////////////////////////////////////////
    ppcb_port_bank u_ppcb_port_bank (.sys_clk(sys_clk), .arst_n(arst_n), .req(req),
        .port1_pin_level(pin_level), .rdata(rdata), .port0_cfg(p0_cfg), .port1_crossbar_skip(p1_skip),
        .port1_data_latch(p1_latch), .port0_pullup_en(pullup_en), .port0_receiver_en(receiver_en));
    ppcb_pad_model u_ppcb_pad_model (.latch(p1_latch), .ext_low(ext_low), .pin_level(pin_level));
    // Free-running 20 MHz clock.
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        // A read answer that never arrived is a mismatch as well.
        if (exp_q.size() != 0) err_count++;
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t rdata got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_vec(input logic [63:0] exp);
        logic [63:0] got;
        got = {p0_cfg, p1_skip, p1_latch, pullup_en, receiver_en};
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t vectors got %h exp %h", $time, got, exp);
        end
    endtask
    // Reference decode kept apart from the design; 0 means nothing answers.
    function automatic int dec(input logic [7:0] a, input logic [3:0] pg);
        if (a == 8'h90) return 1;
        if (a == 8'ha4 && pg == 4'hf) return 3;
        if (pg != 4'h0) return 0;
        case (a)
            8'ha4: return 2;
            8'hd4: return 4;
            8'hd5: return 5;
            8'hf1: return 6;
            default: return 0;
        endcase
    endfunction
    // One request per call; reads note their answer before the shadow takes any write.
    task automatic put(input logic w, r, rmw, bop, input logic [2:0] idx, input logic [7:0] a,
                       input logic [3:0] pg, input logic [7:0] d);
        int s;
        @(posedge sys_clk);
        #1;
        req <= '{wr: w, rd: r, rmw: rmw, bit_op: bop, bit_idx: idx, bit_val: d[0], addr: a, page: pg, wdata: d};
        s = dec(a, pg);
        if (r) exp_q.push_back(s == 1 ? (rmw ? m[1] : m[1] & ~ext_low) : m[s]);
        if (w && s != 0 && bop) m[s][idx] = d[0];
        if (w && s != 0 && !bop) m[s] = d;
    endtask
    task automatic settle();
        repeat (3) put(1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 8'h00, 4'h0, 8'h00);
    endtask
    task automatic chk();
        cmp_vec({m[4], m[6], m[2], m[3], m[5], m[1], m[6], m[6]});
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Read answers land one cycle after the strobe; the falling edge sees them settled.
    always @(posedge sys_clk) begin
        rd_d <= req.rd;
        cycles <= cycles + 1;
    end
    always @(negedge sys_clk) begin
        if (rd_d) cmp_rd(rdata, exp_q.pop_front());
        if (cycles > 3000) begin
            err_count++;
            report_and_stop();
        end
    end
    initial begin
        void'($urandom(32'h281e6b09));
        m = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff};
        repeat (6) @(posedge sys_clk);
        #1;
        arst_n = 1'b1;
        chk();
        foreach (ta[i]) put(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, ta[i], tp[i], 8'h00);
        // Random bytes into every register, each read back on the very next cycle.
        repeat (4) begin
            foreach (ta[i]) begin
                x = 8'($urandom);
                put(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, ta[i], i == 0 ? 4'($urandom) : tp[i], x);
                put(1'b0, 1'b1, 1'b1, 1'b0, 3'h0, ta[i], tp[i], 8'h00);
            end
            settle();
            chk();
        end
        // Analog pins with push-pull drivers still requested.
        put(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 8'hf1, 4'h0, 8'h00);
        put(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 8'ha4, 4'h0, 8'hff);
        settle();
        chk();
        // Shared address on two pages, a refused write on the wrong page and an unmapped read.
        put(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 8'ha4, 4'h0, 8'h3c);
        put(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 8'ha4, 4'hf, 8'hc3);
        put(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 8'hd4, 4'hf, 8'h5a);
        put(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 8'h33, 4'h0, 8'h00);
        foreach (ta[i]) put(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, ta[i], tp[i], 8'h00);
        settle();
        chk();
        // Single-bit writes to the latch and the five configuration registers, then pins pulled low from outside.
        for (int b = 0; b < 8; b++) begin
            put(1'b1, 1'b0, 1'b0, 1'b1, 3'(b), 8'h90, 4'($urandom), 8'($urandom));
            put(1'b1, 1'b0, 1'b0, 1'b1, 3'(b), ta[1 + b % 5], tp[1 + b % 5], 8'($urandom));
        end
        settle();
        ext_low = 8'($urandom);
        put(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 8'h90, 4'h5, 8'h00);
        put(1'b0, 1'b1, 1'b1, 1'b0, 3'h0, 8'h90, 4'h0, 8'h00);
        settle();
        chk();
        // Reset in mid-run must put every register back to its reset value.
        arst_n = 1'b0;
        ext_low = 8'h00;
        m = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff};
        repeat (2) @(posedge sys_clk);
        #1;
        chk();
        arst_n = 1'b1;
        foreach (ta[i]) put(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, ta[i], tp[i], 8'h00);
        settle();
        report_and_stop();
    end
endmodule
